// File: design/sso_top.sv
// Section overhead processor: framer, descrambler, B1 check, SOH rewrite, rescrambler
//
// Behaviour
// - STS-1 frame is 9x90 bytes, TOH first.
// - TOH 27 bytes: three SOH rows, six LOH.
// - STS-N TOH is 3N interleaved columns.
// - Channelized: pointer per payload; concatenated: first only.
// - Concatenation indicators H1=93, H2=FF, positions 2..N.
// - Every STS-1 carries A1=F6 then A2=28.
// - C1 numbering sent and accepted, first is 01.
// - J0 only in STS-1 one, any value.
// - Trace unsupported or unset sends J0 01.
// - Z0 in STS-1s 2..N, loadable with numbering.
// - B1 even BIP-8 over previous scrambled frame.
// - B1 inserted before scrambling, STS-1 one only.
// - E1 orderwire only in STS-1 one.
// - F1 only STS-1 one, readable, writable, passed.
// - D1-D3 in STS-1 one form one channel.
// - Path overhead is first SPE column, passed.
// - Path overhead monitored, never altered here; this design passes it without monitoring it.
// - Regenerator touches section overhead only, passes rest; when concatenated this design also rewrites H1/H2 in STS-1s 2..N.
`timescale 1ns/10ps

module sso_top import sso_pkg::*; #(
  parameter int N_STS = 1,
  parameter int BUF_DEPTH = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  output logic [7:0] o_tx_data,
  output logic o_tx_valid,
  output logic o_tx_sof,
  input wire logic i_tx_ready,
  input wire logic i_concat,
  input wire logic i_trace_en,
  input wire logic [7:0] i_trace_val,
  input wire logic [7:0] i_trace_expect,
  input wire logic i_z0_number,
  input wire logic i_c1_check,
  input wire sso_soh_t i_add,
  input wire sso_soh_en_t i_add_en,
  output sso_soh_t o_drop,
  output logic o_drop_valid,
  output logic o_in_frame,
  output logic [3:0] o_b1_err_cnt,
  output logic o_b1_chk,
  output logic o_trace_mism,
  output logic o_id_err,
  output logic o_conc_err
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [5:0] STS_LAST = 6'(N_STS - 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(BUF_DEPTH - 1);

  typedef struct packed {
    sso_frm_t frm;
    sso_pos_t rpos;
    logic [7:0] rprev;
    logic [6:0] rlfsr;
    logic [7:0] rb1_acc;
    logic [7:0] rb1_hold;
    logic rsof_seen;
    logic rb1_ok;
    sso_ent_t [BUF_DEPTH-1:0] fifo_q;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [6:0] tlfsr;
    logic [7:0] tb1_acc;
    logic [7:0] tb1_hold;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_sof;
    sso_soh_t drop;
    logic drop_valid;
    logic in_frame;
    logic [3:0] b1_cnt;
    logic b1_chk;
    logic trace_mism;
    logic id_err;
    logic conc_err;
  } sso_state_t;

  sso_state_t s_reg;
  sso_state_t s_next;

  logic acc;
  logic pop;
  logic in_sync;
  logic first;
  logic row0_toh;
  logic scr_init;
  logic [6:0] rseed;
  logic [14:0] rkey;
  logic [7:0] desc;
  logic [7:0] sts_id;
  sso_pos_t p;
  sso_ent_t ent;
  sso_ent_t e;
  logic [6:0] tseed;
  logic [14:0] tkey;
  logic [7:0] tb;
  logic [7:0] tout;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    acc = i_rx_valid && s_reg.rx_ready;
    p = s_reg.rpos;
    in_sync = (s_reg.frm == SSO_SYNC);
    first = (p.sts == 6'h00);
    // First TOH row stays unscrambled so the framer can find A1/A2
    row0_toh = in_sync && p.row == ROW_A && p.grp < GRP_SPE;
    scr_init = in_sync && p.row == ROW_A && p.grp == GRP_SPE && first;
    rseed = scr_init ? LFSR_SEED : s_reg.rlfsr;
    rkey = sso_scr(rseed);
    desc = (row0_toh || !in_sync) ? i_rx_data : i_rx_data ^ rkey[7:0];
    sts_id = 8'(p.sts) + STS_FIRST_ID;
    ent.data = desc;
    ent.unscr = row0_toh || !in_sync;
    ent.scr_init = scr_init;
    ent.sof = in_sync && p == '0;
    ent.b1pos = in_sync && first && p.row == ROW_B1 && p.grp == GRP_B1;
    s_next.b1_chk = 1'b0;
    s_next.id_err = 1'b0;
    s_next.conc_err = 1'b0;
    s_next.drop_valid = 1'b0;

    if (acc) begin
      s_next.rprev = i_rx_data;
      if (!in_sync) begin
        if (s_reg.rprev == A1_VAL && i_rx_data == A2_VAL) begin
          s_next.frm = SSO_SYNC;
          s_next.rpos = sso_pos_inc(POS_A2_FIRST, STS_LAST);
          s_next.rsof_seen = 1'b0;
          s_next.rb1_ok = 1'b0;
        end
      end else begin
        s_next.rpos = sso_pos_inc(p, STS_LAST);
        // A wrong last A1 or first A2 drops sync; no flywheel is kept
        if (p.row == ROW_A && ((p.grp == GRP_A1 && p.sts == STS_LAST && i_rx_data != A1_VAL) ||
            (p.grp == GRP_A2 && first && i_rx_data != A2_VAL))) begin
          s_next.frm = SSO_HUNT;
        end
        if (!row0_toh) begin
          s_next.rlfsr = rkey[14:8];
        end
        // Parity runs on the line bytes as received, i.e. scrambled
        if (ent.sof) begin
          s_next.rb1_hold = s_reg.rb1_acc;
          s_next.rb1_acc = i_rx_data;
          s_next.rb1_ok = s_reg.rsof_seen;
          s_next.rsof_seen = 1'b1;
        end else begin
          s_next.rb1_acc = s_reg.rb1_acc ^ i_rx_data;
        end
        if (ent.b1pos && s_reg.rb1_ok) begin
          s_next.b1_chk = 1'b1;
          s_next.b1_cnt = sso_pop8(desc ^ s_reg.rb1_hold);
        end
        // Section overhead rewrite, plus H1/H2 of STS-1s 2..N when concatenated; other line and path bytes pass untouched
        if (p.row == ROW_A && p.grp == GRP_A1) begin
          ent.data = A1_VAL;
        end else if (p.row == ROW_A && p.grp == GRP_A2) begin
          ent.data = A2_VAL;
        end else if (p.row == ROW_A && p.grp == GRP_TRC && first) begin
          s_next.trace_mism = (desc != i_trace_expect);
          ent.data = i_trace_en ? i_trace_val : J0_DEFAULT;
        end else if (p.row == ROW_A && p.grp == GRP_TRC) begin
          s_next.id_err = i_c1_check && (desc != sts_id);
          if (i_z0_number) begin
            ent.data = sts_id;
          end
        end else if (first && p.row == ROW_B1 && p.grp == GRP_E1) begin
          s_next.drop.e1 = desc;
          if (i_add_en.e1) begin
            ent.data = i_add.e1;
          end
        end else if (first && p.row == ROW_B1 && p.grp == GRP_F1) begin
          s_next.drop.f1 = desc;
          if (i_add_en.f1) begin
            ent.data = i_add.f1;
          end
        end else if (first && p.row == ROW_DCC && p.grp == GRP_D1) begin
          s_next.drop.d1 = desc;
          if (i_add_en.d1) begin
            ent.data = i_add.d1;
          end
        end else if (first && p.row == ROW_DCC && p.grp == GRP_D2) begin
          s_next.drop.d2 = desc;
          if (i_add_en.d2) begin
            ent.data = i_add.d2;
          end
        end else if (first && p.row == ROW_DCC && p.grp == GRP_D3) begin
          s_next.drop.d3 = desc;
          s_next.drop_valid = 1'b1;
          if (i_add_en.d3) begin
            ent.data = i_add.d3;
          end
        end else if (!first && i_concat && p.row == ROW_PTR &&
                     (p.grp == GRP_H1 || p.grp == GRP_H2)) begin
          // Only STS-1 one keeps a live pointer in concatenated mode
          s_next.conc_err = (p.grp == GRP_H1) ? desc != H1_CONC : desc != H2_CONC;
          ent.data = (p.grp == GRP_H1) ? H1_CONC : H2_CONC;
        end
      end
      s_next.fifo_q[s_reg.wp] = ent;
      s_next.wp = (s_reg.wp == PTR_LAST) ? '0 : s_reg.wp + PW'(1);
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmit side: B1 slotted in, then rescrambled
    pop = (s_reg.cnt != '0) && (!s_reg.tx_valid || i_tx_ready);
    e = s_reg.fifo_q[s_reg.rp];
    tseed = e.scr_init ? LFSR_SEED : s_reg.tlfsr;
    tkey = sso_scr(tseed);
    tb = e.b1pos ? s_reg.tb1_hold : e.data;
    tout = e.unscr ? tb : tb ^ tkey[7:0];
    if (pop) begin
      s_next.tx_valid = 1'b1;
      s_next.tx_data = tout;
      s_next.tx_sof = e.sof;
      s_next.rp = (s_reg.rp == PTR_LAST) ? '0 : s_reg.rp + PW'(1);
      if (!e.unscr) begin
        s_next.tlfsr = tkey[14:8];
      end
      if (e.sof) begin
        s_next.tb1_hold = s_reg.tb1_acc;
        s_next.tb1_acc = tout;
      end else begin
        s_next.tb1_acc = s_reg.tb1_acc ^ tout;
      end
    end else if (i_tx_ready) begin
      s_next.tx_valid = 1'b0;
    end
    s_next.cnt = CW'(s_reg.cnt + CW'(acc) - CW'(pop));
    s_next.rx_ready = (s_next.cnt < CW'(BUF_DEPTH));
    s_next.in_frame = (s_next.frm == SSO_SYNC);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rx_ready = s_reg.rx_ready;
  assign o_tx_data = s_reg.tx_data;
  assign o_tx_valid = s_reg.tx_valid;
  assign o_tx_sof = s_reg.tx_sof;
  assign o_drop = s_reg.drop;
  assign o_drop_valid = s_reg.drop_valid;
  assign o_in_frame = s_reg.in_frame;
  assign o_b1_err_cnt = s_reg.b1_cnt;
  assign o_b1_chk = s_reg.b1_chk;
  assign o_trace_mism = s_reg.trace_mism;
  assign o_id_err = s_reg.id_err;
  assign o_conc_err = s_reg.conc_err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_a1a2_hit;
    acc && !in_sync && s_reg.rprev == A1_VAL && i_rx_data == A2_VAL;
  endsequence

  sequence seq_last_byte;
    acc && in_sync && p.row == ROW_LAST && p.grp == GRP_LAST && p.sts == STS_LAST &&
      s_next.frm == SSO_SYNC;
  endsequence

  sequence seq_b1_pop;
    pop && e.b1pos;
  endsequence

  hunt_lock_a: assert property (seq_a1a2_hit |=> o_in_frame ##0 s_reg.rpos.grp >= GRP_A2)
    else $error("framer did not lock on A1/A2");

  frame_wrap_a: assert property (seq_last_byte |=> s_reg.rpos == '0)
    else $error("frame counter did not wrap to row 0");

  frame_pattern_a: assert property (acc && in_sync && p.row == ROW_A && p.grp < GRP_TRC |->
    ent.data == ((p.grp == GRP_A1) ? A1_VAL : A2_VAL))
    else $error("framing byte not regenerated");

  trace_byte_a: assert property (acc && in_sync && p.row == ROW_A && p.grp == GRP_TRC && first |->
    ent.data == (i_trace_en ? i_trace_val : J0_DEFAULT))
    else $error("section trace byte wrong");

  z0_number_a: assert property (acc && in_sync && i_z0_number && p.row == ROW_A &&
    p.grp == GRP_TRC && !first |-> ent.data == 8'(p.sts) + STS_FIRST_ID)
    else $error("growth byte not numbered");

  conc_ind_a: assert property (acc && in_sync && i_concat && p.row == ROW_PTR && !first &&
    p.grp < GRP_TRC |-> ent.data == ((p.grp == GRP_H1) ? H1_CONC : H2_CONC))
    else $error("concatenation indicator wrong");

  path_pass_a: assert property (acc && in_sync && p.row > ROW_PTR |-> ent.data == desc)
    else $error("line or path byte altered");

  b1_insert_a: assert property (seq_b1_pop |=> o_tx_valid &&
    (o_tx_data ^ $past(tkey[7:0])) == $past(s_reg.tb1_hold))
    else $error("B1 not inserted from previous frame parity");

  tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
    else $error("transmit byte lost under stall");

  b1_report_a: assert property (acc && ent.b1pos && s_reg.rb1_ok |=> o_b1_chk ##1 !o_b1_chk)
    else $error("B1 check result not pulsed");

  sequence seq_trace_rx;
    acc && in_sync && p.row == ROW_A && p.grp == GRP_TRC && first;
  endsequence

  trace_check_a: assert property (seq_trace_rx |=>
    o_trace_mism == ($past(desc) != $past(i_trace_expect)))
    else $error("trace mismatch flag wrong");

  sof_marks_a: assert property (o_tx_valid && o_tx_sof |-> o_tx_data == A1_VAL)
    else $error("frame start not on framing byte");

  hunt_pass_a: assert property (acc && !in_sync |-> ent.data == i_rx_data && ent.unscr)
    else $error("byte altered while hunting");

  drop_e1_a: assert property (acc && in_sync && first && p.row == ROW_B1 &&
    p.grp == GRP_E1 |=> o_drop.e1 == $past(desc))
    else $error("orderwire byte not dropped");

  d3_strobe_a: assert property (acc && in_sync && first && p.row == ROW_DCC &&
    p.grp == GRP_D3 |=> o_drop_valid ##1 !o_drop_valid)
    else $error("data channel strobe not pulsed");

  buf_full_a: assert property (s_reg.cnt == CW'(BUF_DEPTH) |-> !o_rx_ready)
    else $error("receive ready while buffer full");

endmodule : sso_top

// File: design/sso_pkg.sv
// Shared constants, types and helper functions of the section overhead processor
package sso_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry (per STS-1: 9 rows of 90 columns, 3 transport columns)
  localparam int ROWS = 9;
  localparam int COLS_STS = 90;
  localparam int TOH_COLS = 3;
  localparam int SOH_ROWS = 3;
  localparam int FRAME_BYTES = ROWS * COLS_STS;
  localparam int STS_MAX = 48;

  localparam logic [3:0] ROW_A = 4'h0;
  localparam logic [3:0] ROW_B1 = 4'h1;
  localparam logic [3:0] ROW_DCC = 4'h2;
  localparam logic [3:0] ROW_PTR = 4'(SOH_ROWS);
  localparam logic [3:0] ROW_LAST = 4'(ROWS - 1);
  localparam logic [6:0] GRP_A1 = 7'h00;
  localparam logic [6:0] GRP_A2 = 7'h01;
  localparam logic [6:0] GRP_TRC = 7'h02;
  localparam logic [6:0] GRP_B1 = 7'h00;
  localparam logic [6:0] GRP_E1 = 7'h01;
  localparam logic [6:0] GRP_F1 = 7'h02;
  localparam logic [6:0] GRP_D1 = 7'h00;
  localparam logic [6:0] GRP_D2 = 7'h01;
  localparam logic [6:0] GRP_D3 = 7'h02;
  localparam logic [6:0] GRP_H1 = 7'h00;
  localparam logic [6:0] GRP_H2 = 7'h01;
  localparam logic [6:0] GRP_SPE = 7'(TOH_COLS);
  localparam logic [6:0] GRP_LAST = 7'(COLS_STS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Byte values
  localparam logic [7:0] A1_VAL = 8'hF6;
  localparam logic [7:0] A2_VAL = 8'h28;
  localparam logic [7:0] H1_CONC = 8'h93;
  localparam logic [7:0] H2_CONC = 8'hFF;
  localparam logic [7:0] J0_DEFAULT = 8'h01;
  localparam logic [7:0] STS_FIRST_ID = 8'h01;
  localparam logic [6:0] LFSR_SEED = 7'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [0:0] {SSO_HUNT, SSO_SYNC} sso_frm_t;

  typedef struct packed {
    logic [3:0] row;
    logic [6:0] grp;
    logic [5:0] sts;
  } sso_pos_t;

  localparam sso_pos_t POS_A2_FIRST = '{row: ROW_A, grp: GRP_A2, sts: 6'h00};

  typedef struct packed {
    logic [7:0] e1;
    logic [7:0] f1;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
  } sso_soh_t;

  typedef struct packed {
    logic e1;
    logic f1;
    logic d1;
    logic d2;
    logic d3;
  } sso_soh_en_t;

  typedef struct packed {
    logic [7:0] data;
    logic unscr;
    logic scr_init;
    logic sof;
    logic b1pos;
  } sso_ent_t;

  ////////////////////////////////////////////////////////////////////////////
  // Frame synchronous scrambler x^7+x^6+1, one byte per call: {next state, key}
  function automatic logic [14:0] sso_scr(input logic [6:0] st);
    logic [6:0] s;
    logic [7:0] k;
    s = st;
    k = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      k[i] = s[6];
      s = {s[5:0], s[6] ^ s[5]};
    end
    return {s, k};
  endfunction : sso_scr

  function automatic logic [3:0] sso_pop8(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + 4'(v[i]);
    end
    return c;
  endfunction : sso_pop8

  // Byte-interleaved walk: STS index fastest, then column group, then row
  function automatic sso_pos_t sso_pos_inc(input sso_pos_t p, input logic [5:0] sts_last);
    sso_pos_t q;
    q = p;
    if (p.sts != sts_last) begin
      q.sts = p.sts + 6'h01;
    end else begin
      q.sts = 6'h00;
      if (p.grp != GRP_LAST) begin
        q.grp = p.grp + 7'h01;
      end else begin
        q.grp = 7'h00;
        q.row = (p.row == ROW_LAST) ? 4'h0 : p.row + 4'h1;
      end
    end
    return q;
  endfunction : sso_pos_inc

endpackage : sso_pkg

// File: dv/sso_peer.sv
// Peer line equipment model: scrambled frame source with B1 and random gaps
`timescale 1ns/10ps

module sso_peer #(
  parameter int BAD_FRAME = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_gap,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_valid,
  output logic [3:0] o_frame
);
  logic [9:0] idx_reg;
  logic [6:0] scr_reg;
  logic [7:0] acc_reg;
  logic [7:0] bip_reg;
  logic [7:0] pl;
  logic [7:0] key;
  logic [7:0] tx;
  logic [6:0] s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s = (idx_reg == 10'h003) ? 7'h7F : scr_reg;
    for (int i = 7; i >= 0; i--) begin
      key[i] = s[6];
      s = {s[5:0], s[6] ^ s[5]};
    end
    case (idx_reg)
      10'h000: pl = 8'hF6;
      10'h001: pl = 8'h28;
      10'h002: pl = 8'h5A;
      // Flipped B1 in one frame looks like two line bit errors
      10'h05A: pl = bip_reg ^ ((o_frame == 4'(BAD_FRAME)) ? 8'h05 : 8'h00);
      default: pl = idx_reg[7:0] ^ 8'h3C;
    endcase
    tx = (idx_reg < 10'h003) ? pl : pl ^ key;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_reg <= 10'h000;
      scr_reg <= 7'h7F;
      acc_reg <= 8'h00;
      bip_reg <= 8'h00;
      o_frame <= 4'h0;
      o_valid <= 1'b0;
      o_data <= 8'h00;
    end else if (o_valid && !i_ready) begin
      o_valid <= 1'b1;
    end else if (i_gap) begin
      o_valid <= 1'b0;
      // Line byte inverted on each idle cycle between words
      o_data <= ~o_data;
    end else begin
      o_valid <= 1'b1;
      o_data <= tx;
      scr_reg <= s;
      if (idx_reg == 10'h329) begin
        idx_reg <= 10'h000;
        acc_reg <= 8'h00;
        bip_reg <= acc_reg ^ tx;
        o_frame <= o_frame + 4'h1;
      end else begin
        idx_reg <= idx_reg + 10'h001;
        acc_reg <= acc_reg ^ tx;
      end
    end
  end
endmodule : sso_peer

// File: dv/tb_top.sv
// Self-checking bench for the section overhead processor
`timescale 1ns/10ps

module tb_top;
  import sso_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gap = 1'b1;
  logic rdy = 1'b0;
  logic conc = 1'b0;
  logic tr_en = 1'b0;
  logic z0n = 1'b0;
  logic c1c = 1'b0;
  logic [7:0] tr_val = 8'h00;
  logic [7:0] tr_exp = 8'h00;
  sso_soh_t add = '0;
  sso_soh_en_t add_en = '0;
  logic [7:0] rx_data, tx_data, qin, e, xin, xout, pin, pout;
  logic rx_valid, rx_ready, tx_valid, tx_sof, drop_valid, in_frame, b1_chk, mism;
  logic id_err, conc_err;
  logic [3:0] b1_err, frame;
  logic [9:0] off;
  logic off_ok, pf_ok;
  sso_soh_t drop;
  logic [7:0] q[$];
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 32'hF7D8670E;

  always #20 clk = ~clk;

  sso_peer #(.BAD_FRAME(3)) u_peer (.i_clk(clk), .i_rst_n(rst_n), .i_gap(gap),
    .i_ready(rx_ready), .o_data(rx_data), .o_valid(rx_valid), .o_frame(frame));

  sso_top #(.N_STS(1), .BUF_DEPTH(2)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_rx_data(rx_data), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .o_tx_data(tx_data), .o_tx_valid(tx_valid), .o_tx_sof(tx_sof), .i_tx_ready(rdy),
    .i_concat(conc), .i_trace_en(tr_en), .i_trace_val(tr_val), .i_trace_expect(tr_exp),
    .i_z0_number(z0n), .i_c1_check(c1c), .i_add(add), .i_add_en(add_en),
    .o_drop(drop), .o_drop_valid(drop_valid), .o_in_frame(in_frame),
    .o_b1_err_cnt(b1_err), .o_b1_chk(b1_chk), .o_trace_mism(mism), .o_id_err(id_err),
    .o_conc_err(conc_err));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pl(input logic [9:0] i);
    return i[7:0] ^ 8'h3C;
  endfunction : pl

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    gap <= ($random(seed) & 3) == 0;
    rdy <= ($random(seed) & 3) != 0;
  end

  // Scoreboard: tx stream equals rx stream except rewritten overhead
  always @(posedge clk) begin
    if (!rst_n) begin
      q.delete();
      off_ok = 1'b0;
      pf_ok = 1'b0;
    end else begin
      if (rx_valid && rx_ready) q.push_back(rx_data);
      if (drop_valid) check("drop", drop, {pl(10'h05B), pl(10'h05C), pl(10'h0B4),
        pl(10'h0B5), pl(10'h0B6)});
      if (b1_chk) check("b1 errors", b1_err, (frame == 4'h3) ? 4'h2 : 4'h0);
      if (id_err || conc_err) check("id or concat error", {id_err, conc_err}, 2'b00);
      if (tx_valid && rdy) begin
        qin = q.pop_front();
        if (tx_sof) begin
          if (off_ok) begin
            check("frame length", off, 10'h329);
            pf_ok = 1'b1;
            pin = xin;
            pout = xout;
          end
          off = 10'h000;
          off_ok = 1'b1;
          xin = 8'h00;
          xout = 8'h00;
        end else begin
          off = off + 10'h001;
        end
        if (off_ok) begin
          e = qin;
          case (off)
            10'h000: e = 8'hF6;
            10'h001: e = 8'h28;
            10'h002: e = tr_en ? tr_val : 8'h01;
            10'h05A: e = qin ^ pin ^ pout ^ ((frame == 4'h3) ? 8'h05 : 8'h00);
            10'h05B: e = add_en.e1 ? qin ^ pl(off) ^ add.e1 : qin;
            10'h05C: e = add_en.f1 ? qin ^ pl(off) ^ add.f1 : qin;
            10'h0B4: e = add_en.d1 ? qin ^ pl(off) ^ add.d1 : qin;
            10'h0B5: e = add_en.d2 ? qin ^ pl(off) ^ add.d2 : qin;
            10'h0B6: e = add_en.d3 ? qin ^ pl(off) ^ add.d3 : qin;
            default: e = qin;
          endcase
          if (off != 10'h05A || pf_ok)
            check("tx byte", tx_data, e);
          xin = xin ^ qin;
          xout = xout ^ tx_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int ph = 0; ph < 2; ph++) begin
      rst_n <= 1'b0;
      tr_en <= ph[0];
      tr_val <= 8'($random(seed));
      tr_exp <= ph[0] ? 8'hC3 : 8'h5A;
      conc <= 1'($random(seed));
      z0n <= 1'($random(seed));
      c1c <= 1'($random(seed));
      add <= 40'({$random(seed), $random(seed)});
      add_en <= ph[0] ? 5'h1F : 5'($random(seed));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 25000 && frame != 4'h6; k++) @(posedge clk);
      check("frames done", frame, 4'h6);
      check("in frame", in_frame, 1'b1);
      check("trace mismatch", mism, ph[0]);
    end
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : tb_top
